// file: timer_pkg.sv
package timer_pkg;

  // Register index map, 8-bit data, one register per address
  localparam logic [3:0] ADDR_CTRL_ONE = 4'h0;
  localparam logic [3:0] ADDR_CTRL_TWO = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_CMP1_HI = 4'h3;
  localparam logic [3:0] ADDR_CMP1_LO = 4'h4;
  localparam logic [3:0] ADDR_CMP2_HI = 4'h5;
  localparam logic [3:0] ADDR_CMP2_LO = 4'h6;
  localparam logic [3:0] ADDR_CAP1_HI = 4'h7;
  localparam logic [3:0] ADDR_CAP1_LO = 4'h8;
  localparam logic [3:0] ADDR_CAP2_HI = 4'h9;
  localparam logic [3:0] ADDR_CAP2_LO = 4'ha;
  localparam logic [3:0] ADDR_CNT_HI = 4'hb;
  localparam logic [3:0] ADDR_CNT_LO = 4'hc;

  // control_reg_one fields
  localparam int C1_CAP_IRQ_EN = 7;
  localparam int C1_CMP_IRQ_EN = 6;
  localparam int C1_FORCE_TWO = 5;
  localparam int C1_FORCE_ONE = 4;
  localparam int C1_LEVEL_TWO = 2;
  localparam int C1_EDGE_ONE = 1;
  localparam int C1_LEVEL_ONE = 0;

  // control_reg_two fields
  localparam int C2_PIN_EN_ONE = 7;
  localparam int C2_PIN_EN_TWO = 6;
  localparam int C2_PWM = 5;
  localparam int C2_SINGLE_PULSE = 4;
  localparam int C2_CLK_SEL_HI = 3;
  localparam int C2_CLK_SEL_LO = 2;
  localparam int C2_EDGE_TWO = 1;
  localparam int C2_EXT_EDGE = 0;

  // timer_status_reg fields
  localparam int SR_CAP_FLAG_ONE = 7;
  localparam int SR_CMP_FLAG_ONE = 6;
  localparam int SR_CAP_FLAG_TWO = 4;
  localparam int SR_CMP_FLAG_TWO = 3;

  // Reset and reload values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [15:0] CNT_RESET = 16'hfffc;
  localparam logic [15:0] CAP_PULSE_VALUE = 16'hfffd;
  localparam logic [15:0] CAP_RESET = 16'h0000;

  // Clock select codes and prescale_factor masks
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  localparam logic [2:0] DIV2_MASK = 3'h1;
  localparam logic [2:0] DIV4_MASK = 3'h3;
  localparam logic [2:0] DIV8_MASK = 3'h7;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef enum {MODE_COMPARE, MODE_SINGLE_PULSE, MODE_PWM} timer_mode_e;

endpackage : timer_pkg

// file: timer_compare.sv
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module timer_compare
  import timer_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  input wire logic cpu_int_mask,
  input wire logic capture_in_one,
  input wire logic capture_in_two,
  input wire logic ext_clock_pin,
  output logic [1:0] compare_out_pin,
  output logic [1:0] compare_out_en,
  output logic timer_irq
);

  // Edge detector shared by the capture and external clock inputs
  function automatic logic edge_seen(input logic prev, input logic cur, input logic rising);
    edge_seen = rising ? (cur & ~prev) : (prev & ~cur);
  endfunction : edge_seen

  logic [7:0] control_reg_one;
  logic [7:0] control_reg_two;
  logic [15:0] compare_value_one;
  logic [15:0] compare_value_two;
  logic [15:0] capture_value_one;
  logic [15:0] capture_value_two;
  logic [15:0] counter;
  logic [1:0] inhibit;
  logic compare_flag_one, compare_flag_two, capture_flag_one, capture_flag_two;
  logic arm_cf1, arm_cf2, arm_capture_flag_one, arm_capture_flag_two;
  logic [1:0] sync_cap1, sync_cap2, sync_ext;
  logic prev_cap1, prev_cap2, prev_ext;
  logic [2:0] prescale;
  logic fresh;
  logic tick;
  logic [1:0] match_hit;
  timer_mode_e mode;

  // Bus decode
  logic wr_c1, wr_c2, wr_cmp1_hi, wr_cmp2_hi, rd_status;
  logic acc_cmp1_lo, acc_cmp2_lo, acc_cap1_lo, acc_cap2_lo, acc_cnt_lo;
  assign wr_c1 = reg_req.wr && reg_req.addr == ADDR_CTRL_ONE;
  assign wr_c2 = reg_req.wr && reg_req.addr == ADDR_CTRL_TWO;
  assign wr_cmp1_hi = reg_req.wr && reg_req.addr == ADDR_CMP1_HI;
  assign wr_cmp2_hi = reg_req.wr && reg_req.addr == ADDR_CMP2_HI;
  assign rd_status = reg_req.rd && reg_req.addr == ADDR_STATUS;
  assign acc_cmp1_lo = (reg_req.wr || reg_req.rd) && reg_req.addr == ADDR_CMP1_LO;
  assign acc_cmp2_lo = (reg_req.wr || reg_req.rd) && reg_req.addr == ADDR_CMP2_LO;
  assign acc_cap1_lo = (reg_req.wr || reg_req.rd) && reg_req.addr == ADDR_CAP1_LO;
  assign acc_cap2_lo = (reg_req.wr || reg_req.rd) && reg_req.addr == ADDR_CAP2_LO;
  assign acc_cnt_lo = (reg_req.wr || reg_req.rd) && reg_req.addr == ADDR_CNT_LO;

  // Mode resolution; PWM outranks single pulse
  always_comb begin
    if (control_reg_two[C2_PWM]) begin
      mode = MODE_PWM;
    end else if (control_reg_two[C2_SINGLE_PULSE]) begin
      mode = MODE_SINGLE_PULSE;
    end else begin
      mode = MODE_COMPARE;
    end
  end

  // Pin synchronisers, two flops before any edge logic
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync_cap1 <= 2'h0;
      sync_cap2 <= 2'h0;
      sync_ext <= 2'h0;
      prev_cap1 <= 1'b0;
      prev_cap2 <= 1'b0;
      prev_ext <= 1'b0;
    end else begin
      sync_cap1 <= {sync_cap1[0], capture_in_one};
      sync_cap2 <= {sync_cap2[0], capture_in_two};
      sync_ext <= {sync_ext[0], ext_clock_pin};
      prev_cap1 <= sync_cap1[1];
      prev_cap2 <= sync_cap2[1];
      prev_ext <= sync_ext[1];
    end
  end

  logic cap1_edge, cap2_edge, ext_edge;
  assign cap1_edge = edge_seen(prev_cap1, sync_cap1[1], control_reg_one[C1_EDGE_ONE]);
  assign cap2_edge = edge_seen(prev_cap2, sync_cap2[1], control_reg_two[C2_EDGE_TWO]);
  assign ext_edge = edge_seen(prev_ext, sync_ext[1], control_reg_two[C2_EXT_EDGE]);

  // Single-pulse trigger; capture one is cut off in PWM mode
  logic opm_trigger;
  assign opm_trigger = cap1_edge && mode == MODE_SINGLE_PULSE;

  // Free-running prescaler; masking avoids a restart glitch on reselect
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prescale <= 3'h0;
    end else begin
      prescale <= prescale + 3'h1;
    end
  end

  // Timer tick source
  always_comb begin
    unique case (control_reg_two[C2_CLK_SEL_HI:C2_CLK_SEL_LO])
      CLK_DIV2: tick = (prescale & DIV2_MASK) == DIV2_MASK;
      CLK_DIV4: tick = (prescale & DIV4_MASK) == DIV4_MASK;
      CLK_DIV8: tick = (prescale & DIV8_MASK) == DIV8_MASK;
      CLK_EXT: tick = ext_edge;
    endcase
  end

  // Counter; FFFCh is the sole reload value
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      counter <= CNT_RESET;
    end else if (opm_trigger || acc_cnt_lo) begin
      counter <= CNT_RESET;
    end else if (tick) begin
      counter <= counter + 16'h0001;
    end
  end

  // Marks the one cycle after each counter change, so equality fires once
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fresh <= 1'b0;
    end else begin
      fresh <= opm_trigger || acc_cnt_lo || tick;
    end
  end

  // Comparators, each gated by its own half-write inhibit
  assign match_hit[0] = fresh && !inhibit[0] && counter == compare_value_one;
  assign match_hit[1] = fresh && !inhibit[1] && counter == compare_value_two;

  // Compare value registers; only the bus writes them
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      compare_value_one <= CMP_RESET;
      compare_value_two <= CMP_RESET;
    end else if (reg_req.wr) begin
      unique case (reg_req.addr)
        ADDR_CMP1_HI: compare_value_one[15:8] <= reg_req.wdata;
        ADDR_CMP1_LO: compare_value_one[7:0] <= reg_req.wdata;
        ADDR_CMP2_HI: compare_value_two[15:8] <= reg_req.wdata;
        ADDR_CMP2_LO: compare_value_two[7:0] <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  // Half-write inhibit, lifted by the low byte write
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      inhibit <= 2'h0;
    end else begin
      if (wr_cmp1_hi) begin
        inhibit[0] <= 1'b1;
      end else if (reg_req.wr && reg_req.addr == ADDR_CMP1_LO) begin
        inhibit[0] <= 1'b0;
      end
      if (wr_cmp2_hi) begin
        inhibit[1] <= 1'b1;
      end else if (reg_req.wr && reg_req.addr == ADDR_CMP2_LO) begin
        inhibit[1] <= 1'b0;
      end
    end
  end

  // Control registers; force bits are strobes and never stored
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      control_reg_one <= CTRL_RESET;
      control_reg_two <= CTRL_RESET;
    end else begin
      if (wr_c1) begin
        control_reg_one <= reg_req.wdata & ~(8'h01 << C1_FORCE_ONE) & ~(8'h01 << C1_FORCE_TWO);
      end
      if (wr_c2) begin
        control_reg_two <= reg_req.wdata;
      end
    end
  end

  logic force_one, force_two;
  assign force_one = wr_c1 && reg_req.wdata[C1_FORCE_ONE] && mode == MODE_COMPARE;
  assign force_two = wr_c1 && reg_req.wdata[C1_FORCE_TWO] && mode == MODE_COMPARE;

  // Flag set terms per mode
  logic set_cf1, set_cf2, set_capture_flag_one, set_capture_flag_two;
  assign set_cf1 = match_hit[0] && mode == MODE_COMPARE;
  assign set_cf2 = match_hit[1] && mode != MODE_PWM;
  assign set_capture_flag_one = cap1_edge && mode != MODE_PWM;
  assign set_capture_flag_two = cap2_edge;

  // Clear arming: a status read while the flag is set
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      arm_cf1 <= 1'b0;
      arm_cf2 <= 1'b0;
      arm_capture_flag_one <= 1'b0;
      arm_capture_flag_two <= 1'b0;
    end else if (rd_status) begin
      arm_cf1 <= compare_flag_one;
      arm_cf2 <= compare_flag_two;
      arm_capture_flag_one <= capture_flag_one;
      arm_capture_flag_two <= capture_flag_two;
    end else begin
      if (acc_cmp1_lo) arm_cf1 <= 1'b0;
      if (acc_cmp2_lo) arm_cf2 <= 1'b0;
      if (acc_cap1_lo) arm_capture_flag_one <= 1'b0;
      if (acc_cap2_lo) arm_capture_flag_two <= 1'b0;
    end
  end

  // Sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      compare_flag_one <= 1'b0;
      compare_flag_two <= 1'b0;
      capture_flag_one <= 1'b0;
      capture_flag_two <= 1'b0;
    end else begin
      if (set_cf1) compare_flag_one <= 1'b1;
      else if (arm_cf1 && acc_cmp1_lo) compare_flag_one <= 1'b0;
      if (set_cf2) compare_flag_two <= 1'b1;
      else if (arm_cf2 && acc_cmp2_lo) compare_flag_two <= 1'b0;
      if (set_capture_flag_one) capture_flag_one <= 1'b1;
      else if (arm_capture_flag_one && acc_cap1_lo) capture_flag_one <= 1'b0;
      if (set_capture_flag_two) capture_flag_two <= 1'b1;
      else if (arm_capture_flag_two && acc_cap2_lo) capture_flag_two <= 1'b0;
    end
  end

  // Capture values; trigger loads the fixed pulse value
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      capture_value_one <= CAP_RESET;
      capture_value_two <= CAP_RESET;
    end else begin
      if (opm_trigger) begin
        capture_value_one <= CAP_PULSE_VALUE;
      end else if (cap1_edge && mode == MODE_COMPARE) begin
        capture_value_one <= counter;
      end
      if (cap2_edge) begin
        capture_value_two <= counter;
      end
    end
  end

  // Output latch one; single pulse starts on trigger and ends on match
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      compare_out_pin[0] <= 1'b0;
    end else begin
      unique case (mode)
        MODE_SINGLE_PULSE: begin
          if (opm_trigger) begin
            compare_out_pin[0] <= control_reg_one[C1_LEVEL_TWO];
          end else if (match_hit[0]) begin
            compare_out_pin[0] <= control_reg_one[C1_LEVEL_ONE];
          end
        end
        MODE_COMPARE: begin
          if (force_one || (match_hit[0] && control_reg_two[C2_PIN_EN_ONE])) begin
            compare_out_pin[0] <= control_reg_one[C1_LEVEL_ONE];
          end
        end
        MODE_PWM: ;
      endcase
    end
  end

  // Output latch two; level two belongs to the pulse in single-pulse mode
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      compare_out_pin[1] <= 1'b0;
    end else if (mode == MODE_COMPARE) begin
      if (force_two || (match_hit[1] && control_reg_two[C2_PIN_EN_TWO])) begin
        compare_out_pin[1] <= control_reg_one[C1_LEVEL_TWO];
      end
    end
  end

  // Pin ownership; when clear the port logic keeps the pin
  assign compare_out_en[0] = control_reg_two[C2_PIN_EN_ONE];
  assign compare_out_en[1] = control_reg_two[C2_PIN_EN_TWO];

  // Shared timer request, gated by the CPU mask
  assign timer_irq = !cpu_int_mask &&
    ((control_reg_one[C1_CMP_IRQ_EN] && (compare_flag_one || compare_flag_two)) ||
     (control_reg_one[C1_CAP_IRQ_EN] && (capture_flag_one || capture_flag_two)));

  // Read data, valid the cycle after the strobe only
  logic [7:0] status_byte;
  assign status_byte = (8'(capture_flag_one) << SR_CAP_FLAG_ONE) |
                       (8'(compare_flag_one) << SR_CMP_FLAG_ONE) |
                       (8'(capture_flag_two) << SR_CAP_FLAG_TWO) |
                       (8'(compare_flag_two) << SR_CMP_FLAG_TWO);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        ADDR_CTRL_ONE: reg_rdata <= control_reg_one;
        ADDR_CTRL_TWO: reg_rdata <= control_reg_two;
        ADDR_STATUS: reg_rdata <= status_byte;
        ADDR_CMP1_HI: reg_rdata <= compare_value_one[15:8];
        ADDR_CMP1_LO: reg_rdata <= compare_value_one[7:0];
        ADDR_CMP2_HI: reg_rdata <= compare_value_two[15:8];
        ADDR_CMP2_LO: reg_rdata <= compare_value_two[7:0];
        ADDR_CAP1_HI: reg_rdata <= capture_value_one[15:8];
        ADDR_CAP1_LO: reg_rdata <= capture_value_one[7:0];
        ADDR_CAP2_HI: reg_rdata <= capture_value_two[15:8];
        ADDR_CAP2_LO: reg_rdata <= capture_value_two[7:0];
        ADDR_CNT_HI: reg_rdata <= counter[15:8];
        ADDR_CNT_LO: reg_rdata <= counter[7:0];
        default: reg_rdata <= 8'h00; // Unmapped reads zero
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_CMP_ONLY_BUS: assert property (
    !$stable(compare_value_one) |-> $past(reg_req.wr) &&
      ($past(reg_req.addr) == ADDR_CMP1_HI || $past(reg_req.addr) == ADDR_CMP1_LO))
    else $error("compare value one changed without a bus write");
  AST_MATCH_FLAG: assert property (
    match_hit[0] && mode == MODE_COMPARE |=> compare_flag_one)
    else $error("match did not set compare flag one");
  AST_MATCH_PIN: assert property (
    match_hit[1] && mode == MODE_COMPARE && control_reg_two[C2_PIN_EN_TWO] && !wr_c1
    |=> compare_out_pin[1] == $past(control_reg_one[C1_LEVEL_TWO]))
    else $error("match did not apply level two");
  AST_IRQ_MASK: assert property (
    timer_irq |-> !cpu_int_mask && (compare_flag_one || compare_flag_two ||
      capture_flag_one || capture_flag_two))
    else $error("interrupt raised while masked or without a flag");
  AST_INHIBIT: assert property (
    wr_cmp1_hi ##1 !(reg_req.wr && reg_req.addr == ADDR_CMP1_LO) |-> !match_hit[0] ##1 !match_hit[0])
    else $error("compare one matched while inhibited");
  AST_FLAG_CLEAR: assert property (
    $fell(compare_flag_one) |-> $past(arm_cf1) && $past(acc_cmp1_lo))
    else $error("compare flag one cleared without the two-step sequence");
  AST_OPM_TRIGGER: assert property (
    opm_trigger |=> counter == CNT_RESET && capture_value_one == CAP_PULSE_VALUE &&
      capture_flag_one && compare_out_pin[0] == $past(control_reg_one[C1_LEVEL_TWO]))
    else $error("single-pulse trigger effects missing");
  AST_OPM_NO_CF1: assert property (
    $rose(compare_flag_one) |-> $past(mode) == MODE_COMPARE)
    else $error("compare flag one set outside compare mode");
  AST_FORCE_NO_FLAG: assert property (
    force_one && !set_cf1 && !compare_flag_one |=> !compare_flag_one ##0
      compare_out_pin[0] == $past(control_reg_one[C1_LEVEL_ONE]))
    else $error("force set flag or missed the pin");
  AST_PWM_WINS: assert property (
    control_reg_two[C2_PWM] |-> !opm_trigger && !set_cf1 && !set_cf2)
    else $error("single-pulse or compare active in PWM mode");

  COV_MATCH: cover property (set_cf1 ##[1:100] acc_cmp1_lo && arm_cf1);
  COV_PULSE: cover property (opm_trigger ##[1:1000] match_hit[0]);
  COV_FORCE: cover property (force_two);

endmodule : timer_compare

// file: trigger_load_model.sv
`timescale 1ns/1ps
// Far-side model: trigger source on the capture pins and a load on the compare pins
module trigger_load_model (
  input wire logic clk_sys,
  input wire logic [1:0] compare_out_pin,
  input wire logic [1:0] compare_out_en,
  output logic capture_in_one,
  output logic capture_in_two,
  output logic ext_clock_pin,
  output logic [1:0] load_level
);
  // Released pins float to the pull-up level at the load
  assign load_level[0] = compare_out_en[0] ? compare_out_pin[0] : 1'b1;
  assign load_level[1] = compare_out_en[1] ? compare_out_pin[1] : 1'b1;

  // Idle lines; the external clock pin rests low until pulse_ext drives it
  initial begin
    capture_in_one = 1'b0;
    capture_in_two = 1'b0;
    ext_clock_pin = 1'b0;
  end

  // Each level held four cycles, above the two-cycle synchroniser need
  task automatic fire(input int which);
    @(posedge clk_sys);
    if (which == 1) capture_in_one <= 1'b1;
    else capture_in_two <= 1'b1;
    repeat (4) @(posedge clk_sys);
    if (which == 1) capture_in_one <= 1'b0;
    else capture_in_two <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : fire

  // External clock bursts; each level held four cycles, then the pin rests low
  task automatic pulse_ext(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      ext_clock_pin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ext_clock_pin <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask : pulse_ext
endmodule : trigger_load_model

// file: timer_compare_and_single_pulse_tb_top.sv
`timescale 1ns/1ps
module timer_compare_and_single_pulse_tb_top;
  import timer_pkg::*;
  logic clk_sys;
  logic rst_b;
  reg_req_s reg_req;
  logic [7:0] reg_rdata;
  logic cpu_int_mask;
  logic capture_in_one;
  logic capture_in_two;
  logic ext_clock_pin;
  logic [1:0] compare_out_pin;
  logic [1:0] compare_out_en;
  logic timer_irq;
  logic [1:0] load_level;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [7:0] rd_data;
  int width;

  timer_compare u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .cpu_int_mask(cpu_int_mask), .capture_in_one(capture_in_one),
    .capture_in_two(capture_in_two), .ext_clock_pin(ext_clock_pin),
    .compare_out_pin(compare_out_pin), .compare_out_en(compare_out_en), .timer_irq(timer_irq));

  trigger_load_model u_peer (.clk_sys(clk_sys), .compare_out_pin(compare_out_pin),
    .compare_out_en(compare_out_en), .capture_in_one(capture_in_one),
    .capture_in_two(capture_in_two), .ext_clock_pin(ext_clock_pin), .load_level(load_level));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // Single-cycle strobes, launched just after an edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    reg_req.wr <= 1'b0;
  endtask : wr

  // Read data only stand in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    reg_req.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // Bounded wait for a compare pin level; returns cycles waited
  task automatic wait_pin(input int ch, input logic lvl, output int n);
    n = 0;
    while (compare_out_pin[ch] !== lvl && n < 300) begin
      @(posedge clk_sys);
      #1 n++;
    end
    check(16'(compare_out_pin[ch]), 16'(lvl), "pin wait");
  endtask : wait_pin

  task automatic test_reset;
    rd(ADDR_CMP1_HI, rd_data); check(16'(rd_data), 16'h0080, "cmp1 hi reset");
    rd(ADDR_CMP1_LO, rd_data); check(16'(rd_data), 16'h0000, "cmp1 lo reset");
    rd(ADDR_CMP2_HI, rd_data); check(16'(rd_data), 16'h0080, "cmp2 hi reset");
    check(16'(compare_out_pin), 16'h0000, "latches low");
    check(16'(timer_irq), 16'h0000, "no irq");
    $display("test_reset done");
  endtask : test_reset

  task automatic test_match;
    wr(ADDR_CTRL_TWO, 8'h84);
    wr(ADDR_CTRL_ONE, 8'h41);
    wr(ADDR_CMP1_HI, 8'h00);
    wr(ADDR_CMP1_LO, 8'h10);
    wr(ADDR_CNT_LO, 8'h00);
    wait_pin(0, 1'b1, width);
    check(16'(compare_out_en), 16'h0001, "pin one dedicated");
    // Low byte access before any status read must not clear
    rd(ADDR_CMP1_LO, rd_data); check(16'(rd_data), 16'h0010, "cmp1 lo kept");
    rd(ADDR_STATUS, rd_data);
    check(16'(rd_data[SR_CMP_FLAG_ONE]), 16'h0001, "flag one set");
    check(16'(timer_irq), 16'h0001, "irq on match");
    cpu_int_mask <= 1'b1;
    @(posedge clk_sys); #1;
    check(16'(timer_irq), 16'h0000, "irq masked");
    cpu_int_mask <= 1'b0;
    rd(ADDR_CMP1_HI, rd_data); check(16'(rd_data), 16'h0000, "cmp1 hi kept");
    wr(ADDR_CTRL_ONE, 8'h40);
    rd(ADDR_STATUS, rd_data);
    check(16'(rd_data[SR_CMP_FLAG_ONE]), 16'h0001, "flag kept");
    rd(ADDR_CMP1_LO, rd_data);
    repeat (20) @(posedge clk_sys);
    rd(ADDR_STATUS, rd_data);
    check(16'(rd_data[SR_CMP_FLAG_ONE]), 16'h0000, "flag cleared, no repeat");
    wr(ADDR_CTRL_ONE, 8'h10);
    @(posedge clk_sys); #1;
    check(16'(compare_out_pin[0]), 16'h0000, "forced level");
    rd(ADDR_STATUS, rd_data);
    check(16'(rd_data[SR_CMP_FLAG_ONE]), 16'h0000, "force sets no flag");
    $display("test_match done");
  endtask : test_match

  task automatic test_high_byte_inhibit;
    wr(ADDR_CTRL_ONE, 8'h40);
    wr(ADDR_CMP2_HI, 8'h00);
    wr(ADDR_CNT_LO, 8'h00);
    repeat (40) @(posedge clk_sys);
    rd(ADDR_STATUS, rd_data);
    check(16'(rd_data[SR_CMP_FLAG_TWO]), 16'h0000, "compare two inhibited");
    wr(ADDR_CMP2_LO, 8'h08);
    wr(ADDR_CNT_LO, 8'h00);
    repeat (40) @(posedge clk_sys);
    rd(ADDR_STATUS, rd_data);
    check(16'(rd_data[SR_CMP_FLAG_TWO]), 16'h0001, "compare two resumed");
    check(16'(compare_out_pin[1]), 16'h0000, "pin two general io");
    check(16'(load_level[1]), 16'h0001, "released pin pulled up");
    check(16'(timer_irq), 16'h0001, "irq without pin");
    rd(ADDR_CMP2_LO, rd_data);
    $display("test_high_byte_inhibit done");
  endtask : test_high_byte_inhibit

  task automatic test_single_pulse;
    wr(ADDR_CTRL_TWO, 8'h94);
    wr(ADDR_CTRL_ONE, 8'h86);
    // Pulse of nine ticks programmed as nine minus four, high byte first
    wr(ADDR_CMP1_HI, 8'h00);
    rd(ADDR_STATUS, rd_data);
    wr(ADDR_CMP1_LO, 8'h05);
    fork
      u_peer.fire(1);
      wait_pin(0, 1'b1, width);
    join_any
    wait_pin(0, 1'b0, width);
    check(16'(width >= 15 && width <= 21), 16'h0001, "pulse length");
    rd(ADDR_CAP1_HI, rd_data); check(16'(rd_data), 16'h00ff, "cap hi");
    rd(ADDR_CAP1_LO, rd_data); check(16'(rd_data), 16'h00fd, "cap lo");
    rd(ADDR_STATUS, rd_data);
    check(16'(rd_data[SR_CAP_FLAG_ONE]), 16'h0001, "capture flag one");
    check(16'(rd_data[SR_CMP_FLAG_ONE]), 16'h0000, "no compare flag one");
    check(16'(timer_irq), 16'h0001, "capture irq");
    u_peer.fire(2);
    rd(ADDR_STATUS, rd_data);
    check(16'(rd_data[SR_CAP_FLAG_TWO]), 16'h0001, "capture two works");
    wr(ADDR_CTRL_ONE, 8'h11);
    @(posedge clk_sys); #1;
    check(16'(compare_out_pin[0]), 16'h0000, "force ignored");
    check(16'(load_level[0]), 16'h0000, "load sees latch");
    $display("test_single_pulse done");
  endtask : test_single_pulse

  // External clock, rising edges: three edges move the counter from FFFCh to FFFFh
  task automatic test_ext_clock;
    wr(ADDR_CTRL_TWO, 8'h0d);
    wr(ADDR_CNT_LO, 8'h00);
    u_peer.pulse_ext(3);
    repeat (4) @(posedge clk_sys);
    rd(ADDR_CNT_HI, rd_data); check(16'(rd_data), 16'h00ff, "ext count hi");
    rd(ADDR_CNT_LO, rd_data); check(16'(rd_data), 16'h00ff, "ext count lo");
    $display("test_ext_clock done");
  endtask : test_ext_clock

  // Watchdog well past the few hundred cycles the tests take
  initial begin
    #200000;
    n_mismatch++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    rst_b = 1'b0;
    reg_req = '0;
    cpu_int_mask = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    test_reset();
    test_match();
    test_high_byte_inhibit();
    test_single_pulse();
    test_ext_clock();
    complete_run();
  end
endmodule : timer_compare_and_single_pulse_tb_top
